// [logic/irq_ctrl_params.svh]
// Constants for the interrupt controller: register map, resets, vectors.
// Assumes a plain 8-bit register port driven by the core.
`ifndef IRQ_CTRL_PARAMS_SVH
`define IRQ_CTRL_PARAMS_SVH
// Register offsets
`define OFS_GLOBAL      4'h0
`define OFS_SRCENABLE   4'h1
`define OFS_SRCFLAG     4'h2
`define OFS_HALLCTRL    4'h3
`define OFS_EDGECTRL    4'h4
`define OFS_STATUS      4'h5
// Field positions in source enable/flag registers
`define BIT_EXT         0
`define BIT_NFI         1
`define BIT_CMP0        2
`define BIT_GROUP0      3
`define BIT_HALL_A      4
// Edge field positions in the edge control register
`define POS_EXT_EDGE    0
`define POS_NFI_EDGE    2
`define POS_CMP0_EDGE   4
`define POS_HALL_EDGE   6
// Reset values
`define RST_BYTE        8'h00
// Vector addresses
`define VEC_EXT         13'h0004
`define VEC_NFI         13'h0008
`define VEC_CMP0        13'h000C
`define VEC_GROUP0      13'h0010
`endif

// [logic/irq_ctrl_pkg.sv]
// Types for the interrupt controller.
// Assumes nothing beyond the parameter header.
package irq_ctrl_pkg;
  // Edge select codes: 00 off, 01 rising, 10 falling, 11 both
  typedef enum logic [1:0] {
    EDGE_OFF, EDGE_RISE, EDGE_FALL, EDGE_BOTH
  } edge_type;
  typedef enum logic [2:0] {
    SRC_NONE, SRC_EXT, SRC_NFI, SRC_CMP0, SRC_GROUP0
  } src_type;
endpackage

// [logic/mcu_irq_ctrl.sv]
// Interrupt controller: flags, enables, vectoring, stack-full block, wake.
// Assumes a core that pulses a fetch boundary, reports stack full and
// signals return from interrupt; pins arrive asynchronously.
// Summary of operation
// - Flags set on source events whether or not the source is enabled.
// - A flag vectors only when its own enable is set.
// - Global enable clear blocks every interrupt.
// - Taking an interrupt pushes next PC and loads the vector.
// - Return from interrupt pops the saved PC.
// - Entering a service clears the global enable.
// - Requests arriving while blocked still latch their flags.
// - No request acknowledged while the stack is full.
// - Any newly set flag wakes the device from sleep or idle.
// - Hall flags set on selected edges of filtered Hall signals.
// - Hall vectors via group 0; service clears group flag only.
// - External flag sets on selected edge, or function disabled.
// - External vectors with its enable; service clears flag, global.
// - Pin pull-high selection stays in effect in interrupt use.
// - Filtered input flag sets on selected edge; vectors with own enable.
// - Filtered input service clears its flag and the global enable.
// - Filtered input edge select can disable the function.
// - Comparator 0 flag sets on selected output edge.
// - Comparator 0 vectors when enabled and stack not full.
// - Group flag sets when any grouped source flag sets.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`include "irq_ctrl_params.svh"

module mcu_irq_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter int PC_WIDTH = 13
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  // Register port
  input  wire logic [3:0]          regAddr,
  input  wire logic [7:0]          regWdata,
  input  wire logic                regWrite,
  input  wire logic                regRead,
  output logic      [7:0]          regRdata,
  // Event sources (pins asynchronous, others on ref_clk)
  input  wire logic                externalPin,
  input  wire logic                filteredInputPin,
  input  wire logic                comparator0Out,
  input  wire logic [2:0]          filteredHall,
  input  wire logic [2:0]          pinPullSelect,
  // Core sequencer
  input  wire logic                fetchBoundary,
  input  wire logic                stackFull,
  input  wire logic                returnFromIrq,
  input  wire logic [PC_WIDTH-1:0] nextPc,
  input  wire logic [PC_WIDTH-1:0] stackTopPc,
  input  wire logic                lowPowerMode,
  output logic                     pcLoad,
  output logic      [PC_WIDTH-1:0] pcValue,
  output logic                     stackPush,
  output logic      [PC_WIDTH-1:0] stackPushPc,
  output logic                     stackPop,
  output logic                     wakeUp,
  output logic      [2:0]          pullEnable
);

  // Vector constants are 13 bits wide; a narrower counter would cut them
  if (PC_WIDTH < 13 || PC_WIDTH > 16) begin : g_width_check
    $error("PC_WIDTH must be 13 to 16");
  end

  // Edge match against a two-bit select code
  function automatic logic edgeHit(input logic [1:0] sel,
                                   input logic cur, input logic prev);
    edgeHit = ((sel == EDGE_RISE) && cur && !prev) ||
              ((sel == EDGE_FALL) && !cur && prev) ||
              ((sel == EDGE_BOTH) && (cur != prev));
  endfunction

  // Pin synchronisers: first stage read only by the second
  logic [1:0] pinSync1Q;
  logic [1:0] pinSync2Q;
  logic [1:0] pinPrevQ;
  logic       cmpPrevQ;
  logic [2:0] hallPrevQ;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      pinSync1Q <= 2'h0;
      pinSync2Q <= 2'h0;
      pinPrevQ  <= 2'h0;
      cmpPrevQ  <= 1'b0;
      hallPrevQ <= 3'h0;
    end else begin
      pinSync1Q <= {filteredInputPin, externalPin};
      pinSync2Q <= pinSync1Q;
      pinPrevQ  <= pinSync2Q;
      cmpPrevQ  <= comparator0Out;
      hallPrevQ <= filteredHall;
    end
  end

  // Software state
  logic       global_irq_enable_q, global_irq_enable_d;
  logic [6:0] enable_q, enable_d;   // ext, nfi, cmp0, group0, hall a..c
  logic [6:0] flag_q, flag_d;
  logic [7:0] edge_q, edge_d;
  logic [7:0] rdata_q, rdata_d;
  logic [7:0] flagPrevQ;
  // Sequencer outputs
  logic                pcLoad_q, pcLoad_d;
  logic [PC_WIDTH-1:0] pcValue_q, pcValue_d;
  logic                push_q, push_d;
  logic [PC_WIDTH-1:0] pushPc_q, pushPc_d;
  logic                pop_q, pop_d;
  logic                wake_q, wake_d;
  logic [2:0]          pull_q;
  src_type             taken;
  logic [2:0]          hallEvt;
  logic [6:0]          setEvt;
  logic                groupReq;

  // One detector per Hall channel; all three share one edge select
  for (genvar h = 0; h < 3; h++) begin : g_hall_edge
    assign hallEvt[h] = edgeHit(edge_q[`POS_HALL_EDGE +: 2],
                                filteredHall[h], hallPrevQ[h]);
  end

  // Event detection
  always_comb begin
    setEvt = 7'h00;
    setEvt[`BIT_EXT]  = edgeHit(edge_q[`POS_EXT_EDGE +: 2],
                                pinSync2Q[0], pinPrevQ[0]);
    setEvt[`BIT_NFI]  = edgeHit(edge_q[`POS_NFI_EDGE +: 2],
                                pinSync2Q[1], pinPrevQ[1]);
    setEvt[`BIT_CMP0] = edgeHit(edge_q[`POS_CMP0_EDGE +: 2],
                                comparator0Out, cmpPrevQ);
    setEvt[`BIT_HALL_A +: 3] = hallEvt;
    setEvt[`BIT_GROUP0] = |hallEvt;
    // Hall requests qualify through their per-channel enables
    groupReq = flag_q[`BIT_GROUP0] &&
               |(flag_q[`BIT_HALL_A +: 3] & enable_q[`BIT_HALL_A +: 3]);
  end

  // Arbitration: fixed order ext, nfi, cmp0, group0
  always_comb begin
    taken = SRC_NONE;
    if (fetchBoundary && global_irq_enable_q && !stackFull &&
        !pcLoad_q) begin
      if (flag_q[`BIT_EXT] && enable_q[`BIT_EXT]) begin
        taken = SRC_EXT;
      end else if (flag_q[`BIT_NFI] && enable_q[`BIT_NFI]) begin
        taken = SRC_NFI;
      end else if (flag_q[`BIT_CMP0] && enable_q[`BIT_CMP0]) begin
        taken = SRC_CMP0;
      end else if (groupReq && enable_q[`BIT_GROUP0]) begin
        taken = SRC_GROUP0;
      end
    end
  end

  // Next state of registers and sequencer outputs
  always_comb begin
    global_irq_enable_d = global_irq_enable_q;
    enable_d = enable_q;
    flag_d   = flag_q;
    edge_d   = edge_q;
    rdata_d  = `RST_BYTE;
    if (regWrite) begin
      case (regAddr)
        `OFS_GLOBAL:    global_irq_enable_d = regWdata[0];
        `OFS_SRCENABLE: enable_d = regWdata[6:0];
        `OFS_SRCFLAG:   flag_d   = regWdata[6:0];
        `OFS_EDGECTRL:  edge_d   = regWdata;
        default: ;
      endcase
    end
    if (regRead) begin
      case (regAddr)
        `OFS_GLOBAL:    rdata_d = {7'h00, global_irq_enable_q};
        `OFS_SRCENABLE: rdata_d = {1'b0, enable_q};
        `OFS_SRCFLAG:   rdata_d = {1'b0, flag_q};
        `OFS_EDGECTRL:  rdata_d = edge_q;
        `OFS_STATUS:    rdata_d = {5'h00, pinSync2Q, stackFull};
        default:        rdata_d = `RST_BYTE;
      endcase
    end
    pcLoad_d  = 1'b0;
    pcValue_d = pcValue_q;
    push_d    = 1'b0;
    pushPc_d  = pushPc_q;
    pop_d     = returnFromIrq;
    if (taken != SRC_NONE) begin
      pcLoad_d = 1'b1;
      push_d   = 1'b1;
      pushPc_d = nextPc;
      global_irq_enable_d = 1'b0;
      case (taken)
        SRC_EXT: begin
          pcValue_d = PC_WIDTH'(`VEC_EXT);
          flag_d[`BIT_EXT] = 1'b0;
        end
        SRC_NFI: begin
          pcValue_d = PC_WIDTH'(`VEC_NFI);
          flag_d[`BIT_NFI] = 1'b0;
        end
        SRC_CMP0: begin
          pcValue_d = PC_WIDTH'(`VEC_CMP0);
          flag_d[`BIT_CMP0] = 1'b0;
        end
        default: begin
          pcValue_d = PC_WIDTH'(`VEC_GROUP0);
          flag_d[`BIT_GROUP0] = 1'b0;    // Hall flags kept
        end
      endcase
    end else if (returnFromIrq) begin
      pcLoad_d  = 1'b1;
      pcValue_d = stackTopPc;
    end
    // Hardware set wins over a software clear in the same cycle
    flag_d = flag_d | setEvt;
    wake_d = lowPowerMode && |(flag_q & ~flagPrevQ[6:0]);
  end

  // Register stage
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      global_irq_enable_q <= 1'b0;
      enable_q  <= 7'h00;
      flag_q    <= 7'h00;
      flagPrevQ <= `RST_BYTE;
      edge_q    <= `RST_BYTE;
      rdata_q   <= `RST_BYTE;
      pcLoad_q  <= 1'b0;
      pcValue_q <= '0;
      push_q    <= 1'b0;
      pushPc_q  <= '0;
      pop_q     <= 1'b0;
      wake_q    <= 1'b0;
      pull_q    <= 3'h0;
    end else begin
      global_irq_enable_q <= global_irq_enable_d;
      enable_q  <= enable_d;
      flag_q    <= flag_d;
      flagPrevQ <= {1'b0, flag_q};
      edge_q    <= edge_d;
      rdata_q   <= rdata_d;
      pcLoad_q  <= pcLoad_d;
      pcValue_q <= pcValue_d;
      push_q    <= push_d;
      pushPc_q  <= pushPc_d;
      pop_q     <= pop_d;
      wake_q    <= wake_d;
      pull_q    <= pinPullSelect;  // Pull-up kept in irq use
    end
  end

  assign regRdata    = rdata_q;
  assign pcLoad      = pcLoad_q;
  assign pcValue     = pcValue_q;
  assign stackPush   = push_q;
  assign stackPushPc = pushPc_q;
  assign stackPop    = pop_q;
  assign wakeUp      = wake_q;
  assign pullEnable  = pull_q;

  // Checks: takes gated by the global enable and the stack; entry clears the global enable
  a_global_blocks: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    !global_irq_enable_q |=> !push_q)
    else $error("taken while blocked");
  a_stack_full_block: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    stackFull |=> !push_q)
    else $error("taken with full stack");
  a_entry_clears_global: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    push_q |-> !global_irq_enable_q)
    else $error("global enable left set");

  // Checks: vector load, push and return
  a_push_loads_pc: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    push_q |-> pcLoad_q && pushPc_q == $past(nextPc))
    else $error("push without vector load");
  a_one_take_gap: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    pcLoad_q |=> !push_q)
    else $error("take right after a load");
  a_return_pops: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    returnFromIrq |=> stackPop)
    else $error("no pop on return");
  a_return_loads: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (returnFromIrq && taken == SRC_NONE) |=>
    pcLoad_q && pcValue_q == $past(stackTopPc))
    else $error("return did not restore the pc");

  // Checks: enables and fixed order decide which source is taken
  a_enable_gates: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (push_q && pcValue_q == PC_WIDTH'(`VEC_EXT))
    |-> $past(enable_q[`BIT_EXT]))
    else $error("disabled source taken");
  a_cmp_needs_enable: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (push_q && pcValue_q == PC_WIDTH'(`VEC_CMP0))
    |-> $past(enable_q[`BIT_CMP0] && global_irq_enable_q && !stackFull))
    else $error("comparator taken without its enables");
  a_priority_order: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (push_q && pcValue_q != PC_WIDTH'(`VEC_EXT))
    |-> !$past(flag_q[`BIT_EXT] && enable_q[`BIT_EXT]))
    else $error("lower source taken before external");
  a_hall_needs_enable: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (push_q && pcValue_q == PC_WIDTH'(`VEC_GROUP0))
    |-> $past(enable_q[`BIT_GROUP0] &&
      |(flag_q[`BIT_HALL_A +: 3] & enable_q[`BIT_HALL_A +: 3])))
    else $error("group taken without hall enables");

  // Checks: what a service clears and what it keeps
  a_ext_flag_clear: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (push_q && pcValue_q == PC_WIDTH'(`VEC_EXT) &&
    !$past(setEvt[`BIT_EXT])) |-> !flag_q[`BIT_EXT])
    else $error("external flag not cleared");
  a_filt_flag_clear: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (push_q && pcValue_q == PC_WIDTH'(`VEC_NFI) &&
    !$past(setEvt[`BIT_NFI])) |-> !flag_q[`BIT_NFI])
    else $error("filtered input flag not cleared");
  a_cmp_flag_clear: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (push_q && pcValue_q == PC_WIDTH'(`VEC_CMP0) &&
    !$past(setEvt[`BIT_CMP0])) |-> !flag_q[`BIT_CMP0])
    else $error("comparator flag not cleared");
  a_group_flag_clear: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (push_q && pcValue_q == PC_WIDTH'(`VEC_GROUP0) &&
    !$past(setEvt[`BIT_GROUP0])) |-> !flag_q[`BIT_GROUP0])
    else $error("group flag not cleared");
  a_hall_kept: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (push_q && pcValue_q == PC_WIDTH'(`VEC_GROUP0) &&
    !$past(regWrite)) |-> flag_q[`BIT_HALL_A +: 3] != 3'h0)
    else $error("hall flags lost");

  // Checks: events latch their flags whatever the enables; an off edge select sets none
  a_event_sets_flag: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    setEvt[`BIT_CMP0] |=> flag_q[`BIT_CMP0])
    else $error("comparator event lost");
  a_ext_sets_flag: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (edge_q[`POS_EXT_EDGE +: 2] == EDGE_RISE &&
    pinSync2Q[0] && !pinPrevQ[0]) |=> flag_q[`BIT_EXT])
    else $error("external rising edge lost");
  a_filt_sets_flag: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (edge_q[`POS_NFI_EDGE +: 2] == EDGE_FALL &&
    !pinSync2Q[1] && pinPrevQ[1]) |=> flag_q[`BIT_NFI])
    else $error("filtered input falling edge lost");
  a_event_latches: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (setEvt[`BIT_NFI] && !global_irq_enable_q) |=> flag_q[`BIT_NFI])
    else $error("blocked request not latched");
  a_group_follows: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    |hallEvt |=> flag_q[`BIT_GROUP0])
    else $error("group flag missed");
  a_edge_off_quiet: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (edge_q[`POS_NFI_EDGE +: 2] == EDGE_OFF && !flag_q[`BIT_NFI] &&
    !regWrite) |=> !flag_q[`BIT_NFI])
    else $error("disabled filtered input set its flag");

  // Checks: a freshly set flag wakes the core two cycles later
  a_wake_follows: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (|(setEvt & ~flag_q)) ##1 lowPowerMode |=> wakeUp)
    else $error("new flag did not wake");

endmodule

// [tb/core_model.sv]
// Behavioural core sequencer facing the interrupt controller.
// Assumes one clock; the bench asks for a return through retReq.
`timescale 1ns/100ps

module core_model #(
  parameter int PW = 13
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  // Bench request
  input  wire logic          retReq,
  // Controller side
  input  wire logic          pcLoad,
  input  wire logic [PW-1:0] pcValue,
  input  wire logic          stackPush,
  input  wire logic [PW-1:0] stackPushPc,
  input  wire logic          stackPop,
  output logic               fetchBoundary,
  output logic               stackFull,
  output logic               returnFromIrq,
  output logic [PW-1:0]      nextPc,
  output logic [PW-1:0]      stackTopPc
);
  // One-deep stack so a single take fills it; boundaries every other cycle
  always @(posedge ref_clk) begin
    if (!rstn) begin
      fetchBoundary <= 1'b0;
      stackFull     <= 1'b0;
      returnFromIrq <= 1'b0;
      nextPc        <= 13'h0100;
      stackTopPc    <= 13'h1FFF;
    end else begin
      fetchBoundary <= ~fetchBoundary;
      returnFromIrq <= retReq;
      if (pcLoad) nextPc <= pcValue + 13'h0001;
      if (stackPush) begin
        stackFull  <= 1'b1;
        stackTopPc <= stackPushPc;
      end else if (stackPop) begin
        stackFull  <= 1'b0; // Stack no longer full
        stackTopPc <= ~stackTopPc; // Stale entry is not kept
      end
    end
  end
endmodule

// [tb/tb.sv]
// Self-checking bench for the interrupt controller.
// Assumes the core model above sits on the sequencer side.
`timescale 1ns/100ps

module tb;
  import irq_ctrl_pkg::*;
  logic        ref_clk, rstn, regWrite, regRead, retReq, lowPowerMode;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata, regRdata;
  logic        externalPin, filteredInputPin, comparator0Out;
  logic [2:0]  filteredHall, pinPullSelect, pullEnable;
  logic        fetchBoundary, stackFull, returnFromIrq;
  logic        pcLoad, stackPush, stackPop, wakeUp;
  logic [12:0] nextPc, stackTopPc, pcValue, stackPushPc, lastVec, pushExp;
  int          error_cnt, total_checks, loadCnt, wakeCnt, n0;
  logic [12:0] vecs [4] = '{13'h0004, 13'h0008, 13'h000C, 13'h0010};

  mcu_irq_ctrl DUT (.ref_clk(ref_clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .externalPin(externalPin),
    .filteredInputPin(filteredInputPin), .comparator0Out(comparator0Out),
    .filteredHall(filteredHall), .pinPullSelect(pinPullSelect),
    .fetchBoundary(fetchBoundary), .stackFull(stackFull),
    .returnFromIrq(returnFromIrq), .nextPc(nextPc),
    .stackTopPc(stackTopPc), .lowPowerMode(lowPowerMode), .pcLoad(pcLoad),
    .pcValue(pcValue), .stackPush(stackPush), .stackPushPc(stackPushPc),
    .stackPop(stackPop), .wakeUp(wakeUp), .pullEnable(pullEnable));
  core_model core (.ref_clk(ref_clk), .rstn(rstn), .retReq(retReq),
    .pcLoad(pcLoad), .pcValue(pcValue), .stackPush(stackPush),
    .stackPushPc(stackPushPc), .stackPop(stackPop),
    .fetchBoundary(fetchBoundary), .stackFull(stackFull),
    .returnFromIrq(returnFromIrq), .nextPc(nextPc),
    .stackTopPc(stackTopPc));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task chk(string nm, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task wr(logic [3:0] a, logic [7:0] d);
    @(posedge ref_clk);
    regAddr <= a; regWdata <= d; regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask
  // Data stand in the cycle after the read edge
  task rd(logic [3:0] a, logic [7:0] exp);
    @(posedge ref_clk);
    regAddr <= a; regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    @(posedge ref_clk);
    chk("regRdata", regRdata, exp);
  endtask
  task ret();
    @(posedge ref_clk) retReq <= 1'b1;
    @(posedge ref_clk) retReq <= 1'b0;
    cyc(5);
  endtask
  task drive(logic v);
    externalPin <= v; filteredInputPin <= v; comparator0Out <= v;
    filteredHall <= {3{v}};
    cyc(7); // Pins pass a two-stage synchroniser
  endtask
  task close_out();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Record vector loads, pushes and wake pulses as they stand
  always @(posedge ref_clk) begin
    if (wakeUp === 1'b1) wakeCnt++;
    if (pcLoad === 1'b1) begin
      loadCnt++;
      lastVec = pcValue;
      if (stackPush === 1'b1) begin
        pushExp = nextPc;
        chk("stackPushPc", stackPushPc, nextPc);
      end
    end
  end

  initial begin
    #300us;
    error_cnt++;
    close_out();
  end

  initial begin
    {rstn, regWrite, regRead, retReq, lowPowerMode} = '0;
    {externalPin, filteredInputPin, comparator0Out} = '0;
    {regAddr, regWdata, filteredHall, pinPullSelect} = '0;
    cyc(12);
    rstn <= 1'b1;
    // Reset values, unmapped offset ignored
    wr(4'hF, 8'hFF);
    for (int a = 0; a < 6; a++) rd(a[3:0], 8'h00);
    rd(4'hF, 8'h00);
    // Every edge code on all sources; flags latch with enables off
    lowPowerMode <= 1'b1;
    for (int e = 0; e < 4; e++) begin
      wr(4'h4, {4{e[1:0]}});
      wr(4'h2, 8'h00);
      n0 = wakeCnt;
      drive(1'b1);
      rd(4'h2, e[0] ? 8'h7F : 8'h00);
      chk("wake", wakeCnt - n0, e[0] ? 2 : 0);
      wr(4'h2, 8'h00);
      drive(1'b0);
      rd(4'h2, e[1] ? 8'h7F : 8'h00);
    end
    chk("loads", loadCnt, 0);
    lowPowerMode <= 1'b0;
    pinPullSelect <= 3'b101;
    cyc(3);
    chk("pullEnable", pullEnable, 3'b101);
    // Pending sources served in fixed order
    wr(4'h1, 8'h7F); // Pins already routed as inputs
    wr(4'h2, 8'h1F);
    cyc(6);
    chk("loads", loadCnt, 0);
    for (int i = 0; i < 4; i++) begin
      n0 = loadCnt;
      wr(4'h0, 8'h01);
      cyc(6);
      chk("take", loadCnt - n0, 1);
      chk("vector", lastVec, vecs[i]);
      rd(4'h0, 8'h00);
      ret();
      chk("popped", lastVec, pushExp);
    end
    rd(4'h2, 8'h10);
    // Full stack holds off a nested request until the pop
    wr(4'h2, 8'h01);
    wr(4'h0, 8'h01);
    cyc(6);
    n0 = loadCnt;
    wr(4'h2, 8'h01);
    wr(4'h0, 8'h01);
    cyc(10);
    chk("held", loadCnt - n0, 0);
    ret();
    chk("resumed", loadCnt - n0, 2);
    chk("vector", lastVec, 13'h0004);
    ret();
    close_out();
  end
endmodule
